//--- src/timer2_ccu.sv
// Purpose: 16-bit timer with reload and four capture/compare channels
// Assumes: Avalon-MM slave, byte address = register index * 4, data in bits 7:0
// Notes:   Port one pins pass a 3-stage synchroniser; events act on agreed levels
`timescale 1ns/1ps

module timer2_ccu (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [7:0]  port_in,
	output logic      [7:0]  port_out,
	output logic      [7:0]  port_oe
);
	localparam int NC = timer2_pkg::N_CHAN;

	logic        wait_ff;
	logic [31:0] rdata_ff;
	logic [7:0]  latch_ff, chan_en_ff, ctl_ff, irq_ff, flag_en_ff;
	logic [15:0] count_ff;
	logic [15:0] val_ff [NC];
	logic [4:0]  presc_ff;
	logic [7:0]  s1_ff, s2_ff, s3_ff, filt_ff;
	logic        fall_pend_ff;
	logic [NC-1:0] match_prev_ff, cmp_out_ff;
	logic [7:0]  port_out_ff, port_oe_ff;

	logic        wr_go;
	logic [7:0]  widx, wd, rd_byte;
	logic [7:0]  agree, nxt_filt, rise_ev, fall_ev;
	logic [1:0]  isel, rmode;
	logic [4:0]  presc_lim;
	logic        tick, inc, ovf, trig_fall, cnt_wr;
	logic [15:0] nxt_count;
	logic [1:0]  cmode [NC];
	logic [NC-1:0] edge_ev, cap, match, hit, nxt_cmp_out, ch_set;
	logic [7:0]  nxt_irq, nxt_port_out, nxt_port_oe;

	function automatic logic [7:0] pair_lo(input int c);
		case (c)
			0: return timer2_pkg::IDX_RELOAD_LO;
			1: return timer2_pkg::IDX_CH1_LO;
			2: return timer2_pkg::IDX_CH2_LO;
			default: return timer2_pkg::IDX_CH3_LO;
		endcase
	endfunction

	function automatic logic is_wr(input logic [7:0] idx);
		return wr_go && (widx == idx);
	endfunction

	// Bus slave: one wait cycle, then a single-cycle acknowledge
	assign widx  = avs_address[9:2];
	assign wd    = avs_writedata[7:0];
	assign wr_go = avs_write && !wait_ff && avs_byteenable[0];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wait_ff <= 1'b1;
		end else if (!wait_ff) begin
			wait_ff <= 1'b1;
		end else if (avs_read || avs_write) begin
			wait_ff <= 1'b0;
		end
	end

	always_comb begin
		unique case (widx)
			timer2_pkg::IDX_PORT_LATCH: rd_byte = latch_ff;
			timer2_pkg::IDX_IRQ_REQ:    rd_byte = irq_ff;
			timer2_pkg::IDX_CHAN_EN:    rd_byte = chan_en_ff;
			timer2_pkg::IDX_CH1_LO:     rd_byte = val_ff[1][7:0];
			timer2_pkg::IDX_CH1_HI:     rd_byte = val_ff[1][15:8];
			timer2_pkg::IDX_CH2_LO:     rd_byte = val_ff[2][7:0];
			timer2_pkg::IDX_CH2_HI:     rd_byte = val_ff[2][15:8];
			timer2_pkg::IDX_CH3_LO:     rd_byte = val_ff[3][7:0];
			timer2_pkg::IDX_CH3_HI:     rd_byte = val_ff[3][15:8];
			timer2_pkg::IDX_TCTRL:      rd_byte = ctl_ff;
			timer2_pkg::IDX_FLAG_EN:    rd_byte = flag_en_ff;
			timer2_pkg::IDX_RELOAD_LO:  rd_byte = val_ff[0][7:0];
			timer2_pkg::IDX_RELOAD_HI:  rd_byte = val_ff[0][15:8];
			timer2_pkg::IDX_COUNT_LO:   rd_byte = count_ff[7:0];
			timer2_pkg::IDX_COUNT_HI:   rd_byte = count_ff[15:8];
			timer2_pkg::IDX_PIN_STATE:  rd_byte = filt_ff;
			default:                    rd_byte = timer2_pkg::RST_BYTE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= 32'h00000000;
		end else if (avs_read && wait_ff) begin
			rdata_ff <= {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			latch_ff   <= timer2_pkg::LATCH_RST;
			chan_en_ff <= timer2_pkg::RST_BYTE;
			ctl_ff     <= timer2_pkg::RST_BYTE;
			flag_en_ff <= timer2_pkg::RST_BYTE;
		end else begin
			if (is_wr(timer2_pkg::IDX_PORT_LATCH))
				latch_ff <= wd;
			if (is_wr(timer2_pkg::IDX_CHAN_EN))
				chan_en_ff <= wd;
			if (is_wr(timer2_pkg::IDX_TCTRL))
				ctl_ff <= wd;
			if (is_wr(timer2_pkg::IDX_FLAG_EN))
				flag_en_ff <= wd;
		end
	end

	// Pin synchroniser; a level counts once stages two and three agree
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_ff   <= timer2_pkg::LATCH_RST;
			s2_ff   <= timer2_pkg::LATCH_RST;
			s3_ff   <= timer2_pkg::LATCH_RST;
			filt_ff <= timer2_pkg::LATCH_RST;
		end else begin
			s1_ff   <= port_in;
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			filt_ff <= nxt_filt;
		end
	end

	assign agree    = ~(s2_ff ^ s3_ff);
	assign nxt_filt = (agree & s3_ff) | (~agree & filt_ff);
	assign rise_ev  = ~filt_ff & nxt_filt;
	assign fall_ev  = filt_ff & ~nxt_filt;

	// Prescaler and increment source
	assign isel      = {ctl_ff[timer2_pkg::CTL_ISEL1], ctl_ff[timer2_pkg::CTL_ISEL0]};
	assign rmode     = {ctl_ff[timer2_pkg::CTL_RLD1], ctl_ff[timer2_pkg::CTL_RLD0]};
	assign presc_lim = ctl_ff[timer2_pkg::CTL_PRESCALE] ? timer2_pkg::PRESCALE_SLOW
	                                                     : timer2_pkg::PRESCALE_FAST;
	assign tick      = (presc_ff == presc_lim - 5'h01);
	assign trig_fall = fall_ev[timer2_pkg::PIN_RLD_TRIG];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			presc_ff <= 5'h00;
		end else if (!isel[0] || tick) begin
			presc_ff <= 5'h00;
		end else begin
			presc_ff <= presc_ff + 5'h01;
		end
	end

	// Fall is acted on one clock after it is observed
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fall_pend_ff <= 1'b0;
		end else begin
			fall_pend_ff <= fall_ev[timer2_pkg::PIN_EXT_CNT];
		end
	end

	always_comb begin
		unique case (isel)
			timer2_pkg::ISEL_STOP:    inc = 1'b0;
			timer2_pkg::ISEL_TIMER:   inc = tick;
			timer2_pkg::ISEL_COUNTER: inc = fall_pend_ff;
			timer2_pkg::ISEL_GATED:   inc = tick && filt_ff[timer2_pkg::PIN_EXT_CNT];
		endcase
	end

	// Count, reload and software write, software last so it wins
	// Spelled out: a continuous assign would not follow the bus through a function
	assign cnt_wr = wr_go && (widx == timer2_pkg::IDX_COUNT_LO ||
	                          widx == timer2_pkg::IDX_COUNT_HI);
	assign ovf    = inc && (count_ff == timer2_pkg::COUNT_MAX);

	always_comb begin
		nxt_count = count_ff;
		if (ovf) begin
			if (rmode == timer2_pkg::RLD_MODE0)
				nxt_count = val_ff[0];
			else
				nxt_count = timer2_pkg::RST_WORD;
		end else if (inc) begin
			nxt_count = count_ff + 16'h0001;
		end
		if (rmode == timer2_pkg::RLD_MODE1 && trig_fall)
			nxt_count = val_ff[0];
		if (is_wr(timer2_pkg::IDX_COUNT_LO))
			nxt_count[7:0] = wd;
		if (is_wr(timer2_pkg::IDX_COUNT_HI))
			nxt_count[15:8] = wd;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_ff <= timer2_pkg::RST_WORD;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Channels; channel 0 works on the reload pair
	always_comb begin
		for (int c = 0; c < NC; c++) begin
			cmode[c] = chan_en_ff[2*c +: 2];
			if (c == 0)
				edge_ev[c] = ctl_ff[timer2_pkg::CTL_CH0_EDGE] ? rise_ev[c] : fall_ev[c];
			else
				edge_ev[c] = rise_ev[c];
			cap[c] = (cmode[c] == timer2_pkg::CCM_CAP_EDGE && edge_ev[c]) ||
			         (cmode[c] == timer2_pkg::CCM_CAP_WRITE && is_wr(pair_lo(c)));
			match[c] = (cmode[c] == timer2_pkg::CCM_COMPARE) && (count_ff == val_ff[c]);
			hit[c]   = match[c] && !match_prev_ff[c];
			nxt_cmp_out[c] = cmp_out_ff[c];
			if (hit[c])
				nxt_cmp_out[c] = ctl_ff[timer2_pkg::CTL_CMP_MODE] ? latch_ff[c] : 1'b1;
			else if (ovf && !ctl_ff[timer2_pkg::CTL_CMP_MODE])
				nxt_cmp_out[c] = 1'b0;
			// Write-triggered capture deliberately sets no flag
			ch_set[c] = flag_en_ff[c] &&
			            ((cmode[c] == timer2_pkg::CCM_CAP_EDGE && edge_ev[c]) ||
			             (cmode[c] == timer2_pkg::CCM_COMPARE &&
			              nxt_cmp_out[c] != cmp_out_ff[c]));
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < NC; c++)
				val_ff[c] <= timer2_pkg::RST_WORD;
		end else begin
			for (int c = 0; c < NC; c++) begin
				if (cap[c]) begin
					val_ff[c] <= count_ff;
				end else begin
					if (is_wr(pair_lo(c)))
						val_ff[c][7:0] <= wd;
					if (is_wr(pair_lo(c) + 8'h01))
						val_ff[c][15:8] <= wd;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			match_prev_ff <= '0;
			cmp_out_ff    <= '0;
		end else begin
			match_prev_ff <= match;
			cmp_out_ff    <= nxt_cmp_out;
		end
	end

	// Flags: hardware set beats a same-cycle software write
	always_comb begin
		nxt_irq = is_wr(timer2_pkg::IDX_IRQ_REQ) ? wd : irq_ff;
		if (ovf)
			nxt_irq[timer2_pkg::IRQ_OVF] = 1'b1;
		if (rmode == timer2_pkg::RLD_MODE1 && trig_fall)
			nxt_irq[timer2_pkg::IRQ_EXT] = 1'b1;
		for (int c = 0; c < NC; c++)
			if (ch_set[c])
				nxt_irq[timer2_pkg::IRQ_CH0 + c] = 1'b1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_ff <= timer2_pkg::RST_BYTE;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	// Port drive: compare channels own their pin; others are quasi-open-drain
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			nxt_port_out[b] = latch_ff[b];
			nxt_port_oe[b]  = !latch_ff[b];
		end
		for (int c = 0; c < NC; c++) begin
			if (cmode[c] == timer2_pkg::CCM_COMPARE) begin
				nxt_port_out[c] = cmp_out_ff[c];
				nxt_port_oe[c]  = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			port_out_ff <= timer2_pkg::LATCH_RST;
			port_oe_ff  <= timer2_pkg::RST_BYTE;
		end else begin
			port_out_ff <= nxt_port_out;
			port_oe_ff  <= nxt_port_oe;
		end
	end

	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign port_out        = port_out_ff;
	assign port_oe         = port_oe_ff;

	// Checks
	logic ctl_wr;
	assign ctl_wr = wr_go && (widx == timer2_pkg::IDX_TCTRL);

	sequence s_quiet_11;
		!tick [*8] ##1 !tick [*3];
	endsequence

	property p_fast_period;
		@(posedge clk) disable iff (!resetn || ctl_wr)
		(tick && isel == timer2_pkg::ISEL_TIMER && !ctl_ff[timer2_pkg::CTL_PRESCALE])
			|=> s_quiet_11 ##1 tick;
	endproperty
	a_fast_period: assert property (p_fast_period) else $error("prescale period not 12");

	property p_count_fall;
		@(posedge clk) disable iff (!resetn)
		(fall_ev[timer2_pkg::PIN_EXT_CNT] && isel == timer2_pkg::ISEL_COUNTER && !ctl_wr)
			|=> inc;
	endproperty
	a_count_fall: assert property (p_count_fall) else $error("fall not counted next cycle");

	property p_ovf_flag;
		@(posedge clk) disable iff (!resetn)
		ovf |=> irq_ff[timer2_pkg::IRQ_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

	property p_reload0;
		@(posedge clk) disable iff (!resetn)
		(ovf && rmode == timer2_pkg::RLD_MODE0 && !cnt_wr && !trig_fall)
			|=> count_ff == $past(val_ff[0]);
	endproperty
	a_reload0: assert property (p_reload0) else $error("overflow reload missing");

	property p_wrap;
		@(posedge clk) disable iff (!resetn)
		(ovf && !rmode[1] && !cnt_wr) |=> count_ff == timer2_pkg::RST_WORD;
	endproperty
	a_wrap: assert property (p_wrap) else $error("count did not wrap to zero");

	property p_reload1;
		@(posedge clk) disable iff (!resetn)
		(trig_fall && rmode == timer2_pkg::RLD_MODE1 && !cnt_wr)
			|=> irq_ff[timer2_pkg::IRQ_EXT] && count_ff == $past(val_ff[0]);
	endproperty
	a_reload1: assert property (p_reload1) else $error("trigger reload missing");

	property p_cmp_rise;
		@(posedge clk) disable iff (!resetn)
		(hit[1] && !ctl_ff[timer2_pkg::CTL_CMP_MODE]) |=> cmp_out_ff[1];
	endproperty
	a_cmp_rise: assert property (p_cmp_rise) else $error("compare did not raise pin");

	property p_sw_wins;
		@(posedge clk) disable iff (!resetn)
		(wr_go && widx == timer2_pkg::IDX_COUNT_LO) |=> count_ff[7:0] == $past(wd);
	endproperty
	a_sw_wins: assert property (p_sw_wins) else $error("count write lost");

	property p_cap_write;
		@(posedge clk) disable iff (!resetn)
		(cmode[1] == timer2_pkg::CCM_CAP_WRITE && wr_go && widx == timer2_pkg::IDX_CH1_LO)
			|=> val_ff[1] == $past(count_ff);
	endproperty
	a_cap_write: assert property (p_cap_write) else $error("write capture missing");
endmodule // timer2_ccu

//--- src/timer2_pkg.sv
// Purpose: Shared constants for the timer 2 capture/compare block
// Assumes: Registers sit one per 32-bit word, byte address = index * 4
// Notes:   Reset values are plain defaults; the port latch resets released
package timer2_pkg;
	localparam int unsigned N_CHAN = 4;

	// Register indices
	localparam logic [7:0] IDX_PORT_LATCH = 8'h90;
	localparam logic [7:0] IDX_IRQ_REQ    = 8'hC0;
	localparam logic [7:0] IDX_CHAN_EN    = 8'hC1;
	localparam logic [7:0] IDX_CH1_LO     = 8'hC2;
	localparam logic [7:0] IDX_CH1_HI     = 8'hC3;
	localparam logic [7:0] IDX_CH2_LO     = 8'hC4;
	localparam logic [7:0] IDX_CH2_HI     = 8'hC5;
	localparam logic [7:0] IDX_CH3_LO     = 8'hC6;
	localparam logic [7:0] IDX_CH3_HI     = 8'hC7;
	localparam logic [7:0] IDX_TCTRL      = 8'hC8;
	localparam logic [7:0] IDX_FLAG_EN    = 8'hC9;
	localparam logic [7:0] IDX_RELOAD_LO  = 8'hCA;
	localparam logic [7:0] IDX_RELOAD_HI  = 8'hCB;
	localparam logic [7:0] IDX_COUNT_LO   = 8'hCC;
	localparam logic [7:0] IDX_COUNT_HI   = 8'hCD;
	localparam logic [7:0] IDX_PIN_STATE  = 8'hD0;

	// timer_control fields
	localparam int CTL_ISEL0    = 0;
	localparam int CTL_ISEL1    = 1;
	localparam int CTL_CMP_MODE = 2;
	localparam int CTL_RLD0     = 3;
	localparam int CTL_RLD1     = 4;
	localparam int CTL_CH0_EDGE = 6;
	localparam int CTL_PRESCALE = 7;

	// Input select codes {input_select_bit1, input_select_bit0}
	localparam logic [1:0] ISEL_STOP    = 2'h0;
	localparam logic [1:0] ISEL_TIMER   = 2'h1;
	localparam logic [1:0] ISEL_COUNTER = 2'h2;
	localparam logic [1:0] ISEL_GATED   = 2'h3;

	// Reload codes {reload_mode_bit1, reload_mode_bit0}; 0x is no reload
	localparam logic [1:0] RLD_MODE0 = 2'h2;
	localparam logic [1:0] RLD_MODE1 = 2'h3;

	// Per-channel field of channel_enable_config
	localparam logic [1:0] CCM_OFF       = 2'h0;
	localparam logic [1:0] CCM_CAP_EDGE  = 2'h1;
	localparam logic [1:0] CCM_COMPARE   = 2'h2;
	localparam logic [1:0] CCM_CAP_WRITE = 2'h3;

	// irq_request_register bits; channel flags follow IRQ_CH0
	localparam int IRQ_OVF = 0;
	localparam int IRQ_EXT = 1;
	localparam int IRQ_CH0 = 2;

	// Port one pin positions
	localparam int PIN_RLD_TRIG = 5;
	localparam int PIN_EXT_CNT  = 7;

	localparam logic [4:0]  PRESCALE_FAST = 5'h0C;
	localparam logic [4:0]  PRESCALE_SLOW = 5'h18;
	localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [7:0]  LATCH_RST     = 8'hFF;
endpackage

//--- dv/timer2_pins_model.sv
// Purpose: Far side of port one: count, trigger and channel pin drivers
// Assumes: Undriven open-drain pins float high through a pull-up
// Notes:   Bench moves levels just after a clock edge and holds them for clocks
`timescale 1ns/1ps

module timer2_pins_model (
	input  wire logic       cnt_lvl,
	input  wire logic       trig_lvl,
	input  wire logic [3:0] ch_lvl,
	input  wire logic [7:0] port_out,
	input  wire logic [7:0] port_oe,
	output logic      [7:0] port_in
);
	logic [7:0] ext;

	// Unused pins sit at the pull-up level
	assign ext = {cnt_lvl, 1'h1, trig_lvl, 1'h1, ch_lvl};
	// Wired-and, so a pin driven low by the block reads low
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			port_in[i] = port_oe[i] ? (port_out[i] & ext[i]) : ext[i];
		end
	end
endmodule // timer2_pins_model

//--- dv/timer2_ccu_tb_top.sv
// Purpose: Register-level tests of the timer with capture/compare channels
// Assumes: One wait cycle per bus request, pins filtered over a few clocks
// Notes:   Timed windows sit half a period off any count step, so phase is moot
`timescale 1ns/1ps

module timer2_ccu_tb_top;
	logic        clk;
	logic        resetn;
	logic [9:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  port_in;
	logic [7:0]  port_out;
	logic [7:0]  port_oe;
	logic        cnt_lvl;
	logic        trig_lvl;
	logic [3:0]  ch_lvl;
	int          errors;
	int          samples_checked;

	timer2_ccu dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .port_in(port_in), .port_out(port_out),
		.port_oe(port_oe));

	timer2_pins_model pins (.cnt_lvl(cnt_lvl), .trig_lvl(trig_lvl), .ch_lvl(ch_lvl),
		.port_out(port_out), .port_oe(port_oe), .port_in(port_in));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until waitrequest is sampled low; data taken at that edge
	task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [15:0] q);
		@(posedge clk);
		avs_address <= {idx, 2'h0};
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= ~w;
		// No local limit: only the watchdog may end a stalled wait
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'h0);
		q = {8'h00, avs_readdata[7:0]};
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [15:0] q;
		acc(1'h1, idx, d, q);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [15:0] q);
		acc(1'h0, idx, 8'h00, q);
	endtask

	task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
		wr(idx, v[7:0]);
		wr(idx + 8'h01, v[15:8]);
	endtask

	task automatic rd16(input logic [7:0] idx, output logic [15:0] v);
		logic [15:0] lo;
		logic [15:0] hi;
		rd(idx, lo);
		rd(idx + 8'h01, hi);
		v = {hi[7:0], lo[7:0]};
	endtask

	function automatic logic [7:0] ctl(input logic [1:0] isel, input logic [1:0] rld,
		input logic cm, input logic ps);
		ctl = {ps, 2'h0, rld, cm, isel};
	endfunction

	initial begin
		#800000;
		errors++;
		end_of_test();
	end

	initial begin
		logic [15:0] q;
		logic [1:0]  isel;
		int          pp;
		resetn = 1'h0;
		avs_address = 10'h000;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		cnt_lvl = 1'h1;
		trig_lvl = 1'h1;
		ch_lvl = 4'hB;
		errors = 0;
		samples_checked = 0;
		cyc(3);
		resetn <= 1'h1;

		rd(timer2_pkg::IDX_TCTRL, q);
		chk(q, 16'h0000);
		rd(timer2_pkg::IDX_PORT_LATCH, q);
		chk(q, 16'h00FF);
		wr(8'h55, 8'hA5);
		rd(8'h55, q);
		chk(q, 16'h0000);
		avs_byteenable <= 4'hE;
		wr(timer2_pkg::IDX_TCTRL, 8'h5A);
		avs_byteenable <= 4'hF;
		rd(timer2_pkg::IDX_TCTRL, q);
		chk(q, 16'h0000);
		chk({port_out, port_oe}, 16'hFF00);
		rd(timer2_pkg::IDX_PIN_STATE, q);
		chk(q, 16'h00FB);
		$display("test registers done");

		// Timer, slow timer, gate low, gate high, stopped
		for (int i = 0; i < 5; i++) begin
			isel = (i < 2) ? timer2_pkg::ISEL_TIMER :
				(i < 4) ? timer2_pkg::ISEL_GATED : timer2_pkg::ISEL_STOP;
			pp = (i == 1) ? 24 : 12;
			@(posedge clk);
			cnt_lvl <= (i != 2);
			cyc(4);
			wr16(timer2_pkg::IDX_COUNT_LO, 16'h0000);
			wr(timer2_pkg::IDX_TCTRL, ctl(isel, 2'h0, 1'h0, i == 1));
			cyc(pp * 10 + pp / 2 - 3);
			wr(timer2_pkg::IDX_TCTRL, 8'h00);
			rd16(timer2_pkg::IDX_COUNT_LO, q);
			chk(q, (i == 2 || i == 4) ? 16'h0000 : 16'h000A);
		end
		$display("test timing done");

		wr16(timer2_pkg::IDX_COUNT_LO, 16'h0000);
		wr(timer2_pkg::IDX_TCTRL, ctl(timer2_pkg::ISEL_COUNTER, 2'h0, 1'h0, 1'h0));
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			cnt_lvl <= 1'h0;
			cyc(4);
			cnt_lvl <= 1'h1;
			cyc(4);
		end
		cyc(6);
		wr(timer2_pkg::IDX_TCTRL, 8'h00);
		rd16(timer2_pkg::IDX_COUNT_LO, q);
		chk(q, 16'h0005);
		$display("test counter done");

		wr(timer2_pkg::IDX_IRQ_REQ, 8'h00);
		wr16(timer2_pkg::IDX_COUNT_LO, 16'hFFFE);
		wr(timer2_pkg::IDX_TCTRL, ctl(timer2_pkg::ISEL_TIMER, 2'h0, 1'h0, 1'h0));
		cyc(27);
		wr(timer2_pkg::IDX_TCTRL, 8'h00);
		rd16(timer2_pkg::IDX_COUNT_LO, q);
		chk(q, 16'h0000);
		cyc(50);
		rd(timer2_pkg::IDX_IRQ_REQ, q);
		chk(q, 16'h0001);
		wr(timer2_pkg::IDX_IRQ_REQ, 8'h00);
		wr16(timer2_pkg::IDX_RELOAD_LO, 16'h1234);
		wr16(timer2_pkg::IDX_COUNT_LO, 16'hFFFF);
		wr(timer2_pkg::IDX_TCTRL, ctl(timer2_pkg::ISEL_TIMER, timer2_pkg::RLD_MODE0, 1'h0, 1'h0));
		cyc(15);
		wr(timer2_pkg::IDX_TCTRL, 8'h00);
		rd16(timer2_pkg::IDX_COUNT_LO, q);
		chk(q, 16'h1234);
		wr(timer2_pkg::IDX_IRQ_REQ, 8'h00);
		wr16(timer2_pkg::IDX_COUNT_LO, 16'h0000);
		wr(timer2_pkg::IDX_TCTRL, ctl(timer2_pkg::ISEL_STOP, timer2_pkg::RLD_MODE1, 1'h0, 1'h0));
		@(posedge clk);
		trig_lvl <= 1'h0;
		cyc(8);
		trig_lvl <= 1'h1;
		rd16(timer2_pkg::IDX_COUNT_LO, q);
		chk(q, 16'h1234);
		rd(timer2_pkg::IDX_IRQ_REQ, q);
		chk(q, 16'h0002);
		$display("test reload done");

		wr(timer2_pkg::IDX_TCTRL, 8'h00);
		wr(timer2_pkg::IDX_FLAG_EN, 8'h0F);
		wr(timer2_pkg::IDX_IRQ_REQ, 8'h00);
		wr16(timer2_pkg::IDX_COUNT_LO, 16'hABCD);
		wr(timer2_pkg::IDX_CHAN_EN, {4'h0, timer2_pkg::CCM_CAP_WRITE, 2'h0});
		wr(timer2_pkg::IDX_CH1_LO, 8'h55);
		rd16(timer2_pkg::IDX_CH1_LO, q);
		chk(q, 16'hABCD);
		rd(timer2_pkg::IDX_IRQ_REQ, q);
		chk(q, 16'h0000);
		wr16(timer2_pkg::IDX_COUNT_LO, 16'h4321);
		wr(timer2_pkg::IDX_CHAN_EN, {2'h0, timer2_pkg::CCM_CAP_EDGE, 2'h0,
			timer2_pkg::CCM_CAP_EDGE});
		@(posedge clk);
		ch_lvl <= 4'hE;
		cyc(8);
		wr16(timer2_pkg::IDX_COUNT_LO, 16'h1111);
		// Wrong-direction edges on both channels must not capture
		@(posedge clk);
		ch_lvl <= 4'hB;
		cyc(8);
		rd16(timer2_pkg::IDX_RELOAD_LO, q);
		chk(q, 16'h4321);
		rd16(timer2_pkg::IDX_CH2_LO, q);
		chk(q, 16'h4321);
		rd(timer2_pkg::IDX_IRQ_REQ, q);
		chk(q, 16'h0014);
		// Channel 0 set to rising edges: the fall must not capture, the rise must
		wr(timer2_pkg::IDX_TCTRL, 8'h40);
		wr(timer2_pkg::IDX_CHAN_EN, {6'h00, timer2_pkg::CCM_CAP_EDGE});
		wr16(timer2_pkg::IDX_COUNT_LO, 16'h2222);
		@(posedge clk);
		ch_lvl <= 4'hA;
		cyc(8);
		wr16(timer2_pkg::IDX_COUNT_LO, 16'h3333);
		@(posedge clk);
		ch_lvl <= 4'hB;
		cyc(8);
		wr(timer2_pkg::IDX_TCTRL, 8'h00);
		rd16(timer2_pkg::IDX_RELOAD_LO, q);
		chk(q, 16'h3333);
		$display("test capture done");

		wr(timer2_pkg::IDX_IRQ_REQ, 8'h00);
		wr(timer2_pkg::IDX_CHAN_EN, {4'h0, timer2_pkg::CCM_COMPARE, 2'h0});
		wr16(timer2_pkg::IDX_CH1_LO, 16'h0005);
		wr16(timer2_pkg::IDX_COUNT_LO, 16'h0000);
		wr(timer2_pkg::IDX_TCTRL, ctl(timer2_pkg::ISEL_TIMER, 2'h0, 1'h0, 1'h0));
		cyc(84);
		chk({15'h0000, port_out[1] & port_oe[1]}, 16'h0001);
		wr(timer2_pkg::IDX_PORT_LATCH, 8'hFD);
		cyc(2);
		chk({15'h0000, port_out[1]}, 16'h0001);
		wr(timer2_pkg::IDX_TCTRL, 8'h00);
		rd(timer2_pkg::IDX_IRQ_REQ, q);
		chk(q, 16'h0008);
		wr16(timer2_pkg::IDX_COUNT_LO, 16'h0000);
		wr(timer2_pkg::IDX_TCTRL, ctl(timer2_pkg::ISEL_TIMER, 2'h0, 1'h1, 1'h0));
		cyc(3);
		chk({15'h0000, port_out[1]}, 16'h0001);
		cyc(84);
		chk({15'h0000, port_out[1]}, 16'h0000);
		wr(timer2_pkg::IDX_TCTRL, 8'h00);
		$display("test compare done");
		end_of_test();
	end
endmodule // timer2_ccu_tb_top
